/* File: hw/adc_acquisition_control.sv */
// Function
// - ACQ bit 0 write starts self-timed acquisition
// - Self-timed acquisition lasts three ticks, converts next
// - ACQ bit 1 write starts open-ended acquisition
// - Second write with ACQ 0 starts conversion
// - Second write may change power mode safely
// - Interrupt goes low when result ready
// - Interrupt returns high on read or write
// - Power-down codes keep last clock source
// - Reset selects external conversion clock
// - Power codes: shutdown, standby, internal, external
// - Bit 5 selects acquisition timing
// - Bit 4 selects single-ended or pseudo-differential
// - Bit 3 selects unipolar or bipolar
// - Low three bits select channel
// - Internal clock mode gives 3.9 us conversion
// - Every conversion takes thirteen clock ticks
// - Write during conversion aborts, restarts acquisition
// - Tracking begins on write strobe rising edge
// - Read returns low byte or padded high nibble
`timescale 1ns/1ps
`default_nettype none

module adc_acquisition_control
    import adc_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic cs_n,                  // Chip select
    input wire logic wr_n,                  // Write strobe
    input wire logic rd_n,                  // Read strobe
    input wire logic high_byte_enable,      // Read upper nibble when high
    input wire logic [7:0] data_in,         // Data bus, pin input
    output logic [7:0] data_out,            // Data bus, pin output
    output logic data_oe_n,                 // Low while the device drives the bus
    input wire logic conv_clk_in,           // Host-supplied conversion clock
    input wire logic compare_high,          // Comparator: input above DAC trial
    output logic [RES_W-1:0] dac_code,      // SAR trial code
    output logic track,                     // Track-and-hold tracking
    output ctrl_s active_config,            // Mux, polarity and power settings
    output logic ext_clk_sel,               // Conversion clock is the pin
    output logic shutdown_active,           // Full power-down in effect
    output logic standby_active,            // Standby power-down in effect
    output logic int_n                      // Conversion done, active low
);

    // Trial step: keep the tested bit only if the input is still above it
    function automatic logic [RES_W-1:0] sar_decide(input logic [RES_W-1:0] trial,
                                                    input logic [RES_W-1:0] mask,
                                                    input logic keep);
        sar_decide = keep ? trial : (trial & ~mask);
    endfunction

    seq_state_e state_reg;          // Sequencer state
    ctrl_s ctrl_reg;                // Latched control byte
    ctrl_s wr_byte;                 // Byte on the bus, as fields
    logic ext_clk_sel_reg;          // Clock source choice
    logic wr_prev_reg;              // Strobe history for edge detection
    logic rd_prev_reg;
    logic [CNT_W-1:0] cnt_reg;      // Ticks within acquisition or conversion
    logic [RES_W-1:0] trial_reg;    // Current DAC trial
    logic [RES_W-1:0] mask_reg;     // Bit under test
    logic [RES_W-1:0] result_reg;   // Last finished result
    logic [RES_W-1:0] decided;      // Trial after this step's decision
    logic int_n_reg;
    logic [7:0] data_out_reg;
    logic oe_n_reg;
    logic wr_event;                 // Write strobe rising edge with select low
    logic rd_event;                 // Start of a read cycle
    logic ends_ext;                 // Write closes an open-ended acquisition
    logic pd_normal;                // Written power code is a run mode
    logic running;
    logic tick;                     // One conversion clock period
    logic done;                     // Last conversion tick

    assign wr_byte = ctrl_s'(data_in);
    assign wr_event = !cs_n && wr_n && !wr_prev_reg;
    assign rd_event = !cs_n && !rd_n && rd_prev_reg;
    assign ends_ext = (state_reg == ST_ACQ_EXT) && !wr_byte.acq_ext;
    assign pd_normal = (wr_byte.power_mode == PM_INT_CLK) || (wr_byte.power_mode == PM_EXT_CLK);
    assign running = (state_reg == ST_ACQ_INT) || (state_reg == ST_CONVERT);
    assign done = tick && (state_reg == ST_CONVERT) && (cnt_reg == CONV_LAST) && !wr_event;
    assign decided = sar_decide(trial_reg, mask_reg, compare_high);

    // Conversion clock source: divider gives 13 x 3 x 100 ns = 3.9 us,
    // the nearest whole-cycle figure at or above 3.6 us
    conv_tick_gen u_tick (
        .clk(clk),
        .reset(reset),
        .ext_clk_sel(ext_clk_sel_reg),
        .run(running),
        .conv_clk_in(conv_clk_in),
        .tick(tick)
    );

    // Strobe history; idle bus level is high
    always_ff @(posedge clk) begin
        if (reset) begin
            wr_prev_reg <= 1'b1;
            rd_prev_reg <= 1'b1;
        end else begin
            wr_prev_reg <= wr_n | cs_n;
            rd_prev_reg <= rd_n | cs_n;
        end
    end

    // Control byte latch
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_reg <= CTRL_RESET;
        end else if (wr_event && ends_ext) begin
            // Closing write: only the power code is taken, the mux stays put
            ctrl_reg.power_mode <= wr_byte.power_mode;
        end else if (wr_event) begin
            ctrl_reg <= wr_byte;
        end
    end

    // Clock source; power-down codes leave it alone
    always_ff @(posedge clk) begin
        if (reset) begin
            ext_clk_sel_reg <= 1'b1;
        end else if (wr_event && pd_normal) begin
            ext_clk_sel_reg <= (wr_byte.power_mode == PM_EXT_CLK);
        end
    end

    // Sequencer
    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= ST_IDLE;
        end else if (wr_event) begin
            if (ends_ext) begin
                state_reg <= ST_CONVERT;
            end else if (!pd_normal) begin
                state_reg <= ST_IDLE; // Power-down request, no conversion
            end else if (wr_byte.acq_ext) begin
                state_reg <= ST_ACQ_EXT;
            end else begin
                state_reg <= ST_ACQ_INT;
            end
        end else if (tick) begin
            case (state_reg)
                ST_ACQ_INT: begin
                    if (cnt_reg == ACQ_LAST) begin
                        state_reg <= ST_CONVERT;
                    end
                end
                ST_CONVERT: begin
                    if (cnt_reg == CONV_LAST) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= state_reg;
                end
            endcase
        end
    end

    // Tick counter, cleared by every write and at each phase boundary
    always_ff @(posedge clk) begin
        if (reset || wr_event) begin
            cnt_reg <= CNT_ZERO;
        end else if (tick && (state_reg == ST_ACQ_INT)) begin
            cnt_reg <= (cnt_reg == ACQ_LAST) ? CNT_ZERO : cnt_reg + CNT_ONE;
        end else if (tick && (state_reg == ST_CONVERT)) begin
            cnt_reg <= (cnt_reg == CONV_LAST) ? CNT_ZERO : cnt_reg + CNT_ONE;
        end
    end

    // Successive approximation: tick 0 samples, ticks 1..12 resolve MSB first
    always_ff @(posedge clk) begin
        if (reset) begin
            trial_reg <= RES_ZERO;
            mask_reg <= RES_ZERO;
        end else if (tick && (state_reg == ST_CONVERT) && !wr_event) begin
            if (cnt_reg == CNT_ZERO) begin
                trial_reg <= SAR_MSB;
                mask_reg <= SAR_MSB;
            end else begin
                trial_reg <= decided | (mask_reg >> 1);
                mask_reg <= mask_reg >> 1;
            end
        end
    end

    // Result only changes at completion, so a slow reader sees a stable value
    always_ff @(posedge clk) begin
        if (reset) begin
            result_reg <= RES_ZERO;
        end else if (done) begin
            result_reg <= decided;
        end
    end

    // Completion flag; completion wins over a read in the same cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            int_n_reg <= 1'b1;
        end else if (done) begin
            int_n_reg <= 1'b0;
        end else if (wr_event || rd_event) begin
            int_n_reg <= 1'b1;
        end
    end

    // Read port: low byte, or high nibble padded by polarity
    always_ff @(posedge clk) begin
        if (reset) begin
            data_out_reg <= 8'h00;
            oe_n_reg <= 1'b1;
        end else begin
            oe_n_reg <= cs_n | rd_n;
            if (high_byte_enable) begin
                data_out_reg <= {ctrl_reg.unipolar ? HI_PAD_ZERO : {4{result_reg[RES_W-1]}},
                                 result_reg[RES_W-1:8]};
            end else begin
                data_out_reg <= result_reg[7:0];
            end
        end
    end

    assign data_out = data_out_reg;
    assign data_oe_n = oe_n_reg;
    assign int_n = int_n_reg;
    assign dac_code = trial_reg;
    assign active_config = ctrl_reg;
    assign ext_clk_sel = ext_clk_sel_reg;
    assign track = (state_reg == ST_ACQ_INT) || (state_reg == ST_ACQ_EXT);
    // New power code takes effect once no conversion is pending
    assign shutdown_active = (state_reg == ST_IDLE) && (ctrl_reg.power_mode == PM_SHUTDOWN);
    assign standby_active = (state_reg == ST_IDLE) && (ctrl_reg.power_mode == PM_STANDBY);

    chk_int_acq_start: assert property (@(posedge clk) disable iff (reset)
        wr_event && !ends_ext && pd_normal && !wr_byte.acq_ext |=> state_reg == ST_ACQ_INT && track)
        else $error("self-timed acquisition did not start");

    chk_acq_to_conv: assert property (@(posedge clk) disable iff (reset)
        state_reg == ST_ACQ_INT && tick && cnt_reg == ACQ_LAST && !wr_event
        |=> state_reg == ST_CONVERT && cnt_reg == CNT_ZERO)
        else $error("acquisition did not end after three ticks");

    chk_ext_acq_hold: assert property (@(posedge clk) disable iff (reset)
        state_reg == ST_ACQ_EXT && !wr_event |=> state_reg == ST_ACQ_EXT)
        else $error("open-ended acquisition ended without a write");

    chk_ext_acq_close: assert property (@(posedge clk) disable iff (reset)
        state_reg == ST_ACQ_EXT && wr_event && !wr_byte.acq_ext |=> state_reg == ST_CONVERT && !track)
        else $error("second write did not start conversion");

    chk_close_power: assert property (@(posedge clk) disable iff (reset)
        ends_ext && wr_event |=> ctrl_reg.power_mode == $past(wr_byte.power_mode)
        && ctrl_reg.channel == $past(ctrl_reg.channel) && state_reg == ST_CONVERT)
        else $error("closing write mishandled power code or channel");

    chk_done_int: assert property (@(posedge clk) disable iff (reset)
        done |=> !int_n && result_reg == $past(decided))
        else $error("completion not flagged");

    chk_int_clear: assert property (@(posedge clk) disable iff (reset)
        (wr_event || rd_event) && !done |=> int_n)
        else $error("interrupt not released by read or write");

    chk_clk_keep: assert property (@(posedge clk) disable iff (reset)
        wr_event && (wr_byte.power_mode == PM_SHUTDOWN || wr_byte.power_mode == PM_STANDBY)
        |=> $stable(ext_clk_sel_reg))
        else $error("power-down code changed clock source");

    chk_reset_clk: assert property (@(posedge clk)
        reset |=> ext_clk_sel_reg && int_n)
        else $error("reset did not select external clock");

    chk_conv_abort: assert property (@(posedge clk) disable iff (reset)
        state_reg == ST_CONVERT && wr_event && pd_normal && !wr_byte.acq_ext
        |=> state_reg == ST_ACQ_INT && cnt_reg == CNT_ZERO && int_n)
        else $error("write did not abort conversion");

    chk_conv_len: assert property (@(posedge clk) disable iff (reset)
        state_reg == ST_CONVERT && tick && cnt_reg == CONV_LAST && !wr_event
        |=> state_reg == ST_IDLE && !int_n)
        else $error("conversion ran past thirteen ticks");

    chk_read_high: assert property (@(posedge clk) disable iff (reset)
        high_byte_enable && !ctrl_reg.unipolar |=> data_out[7:4] == {4{$past(result_reg[RES_W-1])}})
        else $error("bipolar high nibble not sign padded");

    chk_hold_result: assert property (@(posedge clk) disable iff (reset)
        !int_n && !wr_event && !rd_event |=> !int_n && $stable(result_reg))
        else $error("result or interrupt moved before read");

endmodule // adc_acquisition_control

`default_nettype wire

/* File: hw/adc_ctrl_pkg.sv */
package adc_ctrl_pkg;

    // Control byte layout, most significant field first
    typedef struct packed {
        logic [1:0] power_mode;     // Clock and power-down mode
        logic acq_ext;              // 1: acquisition ends on a second write
        logic single_ended;         // 1: input referred to the shared return
        logic unipolar;             // 1: unipolar, 0: bipolar two's complement
        logic [2:0] channel;        // Input or input pair
    } ctrl_s;

    // Sequencer states, Gray coded along idle, acquire, convert
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACQ_INT = 2'b01,
        ST_CONVERT = 2'b11,
        ST_ACQ_EXT = 2'b10
    } seq_state_e;

    // Power mode codes
    localparam logic [1:0] PM_SHUTDOWN = 2'h0;
    localparam logic [1:0] PM_STANDBY = 2'h1;
    localparam logic [1:0] PM_INT_CLK = 2'h2;
    localparam logic [1:0] PM_EXT_CLK = 2'h3;

    // After power-up: normal operation on the external conversion clock
    localparam ctrl_s CTRL_RESET = '{power_mode: PM_EXT_CLK, acq_ext: 1'b0, single_ended: 1'b0,
                                     unipolar: 1'b0, channel: 3'h0};

    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int INT_CONV_TIME_NS = 3600;
    localparam int CONV_TICKS = 13;
    localparam int ACQ_TICKS = 3;
    // System clocks per on-chip conversion clock period, rounded up
    localparam int INT_TICK_CYCLES = (INT_CONV_TIME_NS + CONV_TICKS * CLK_PERIOD_NS - 1)
                                     / (CONV_TICKS * CLK_PERIOD_NS);
    localparam int DIV_W = 2;
    localparam logic [DIV_W-1:0] INT_TICK_LAST = DIV_W'(INT_TICK_CYCLES - 1);

    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
    localparam logic [CNT_W-1:0] ACQ_LAST = CNT_W'(ACQ_TICKS - 1);
    localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_TICKS - 1);

    // Result layout
    localparam int RES_W = 12;
    localparam logic [RES_W-1:0] SAR_MSB = 12'h800;
    localparam logic [RES_W-1:0] RES_ZERO = 12'h000;
    localparam logic [3:0] HI_PAD_ZERO = 4'h0;

endpackage

/* File: hw/conv_tick_gen.sv */
`timescale 1ns/1ps
`default_nettype none

// One-cycle enable per conversion clock period, from the on-chip divider
// or from falling edges of the host-supplied clock
module conv_tick_gen
    import adc_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic ext_clk_sel,
    input wire logic run,
    input wire logic conv_clk_in,
    output logic tick
);

    logic [DIV_W-1:0] div_cnt_reg; // On-chip clock divider
    logic ext_prev_reg;            // Previous level of the external clock
    logic int_tick;

    // Divider restarts whenever the sequencer is idle, so that the first
    // acquisition tick falls a full period after a write made while not running
    always_ff @(posedge clk) begin
        if (reset || !run) begin
            div_cnt_reg <= '0;
        end else if (div_cnt_reg == INT_TICK_LAST) begin
            div_cnt_reg <= '0;
        end else begin
            div_cnt_reg <= div_cnt_reg + 1'b1;
        end
    end

    // Edge memory for the external clock; the pin is already synchronous
    always_ff @(posedge clk) begin
        if (reset) begin
            ext_prev_reg <= 1'b0;
        end else begin
            ext_prev_reg <= conv_clk_in;
        end
    end

    assign int_tick = run && (div_cnt_reg == INT_TICK_LAST);

    // Sampling and SAR steps advance on falling edges of the external clock
    assign tick = ext_clk_sel ? (run && ext_prev_reg && !conv_clk_in) : int_tick;

endmodule // conv_tick_gen

`default_nettype wire

/* File: tb/host_side_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Far side of the converter: conversion clock source and an ideal comparator
module host_side_model
    import adc_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic ext_run,                 // Run the conversion clock pin
    input wire logic [RES_W-1:0] analog,      // Held sample value
    input wire logic [RES_W-1:0] dac_code,    // Trial code from the device
    output logic conv_clk_in,
    output logic compare_high
);
    logic [1:0] div_reg; // Half period of two clk cycles

    // Pin toggles only while asked to run, otherwise it rests at a fixed level
    always @(negedge clk) begin
        if (reset || !ext_run) begin
            div_reg <= 2'h0;
            conv_clk_in <= 1'b0;
        end else begin
            div_reg <= div_reg + 2'h1;
            if (div_reg[0]) begin
                conv_clk_in <= ~conv_clk_in;
            end
        end
    end

    // Ideal comparator, so the finished result equals the sample
    assign compare_high = (analog >= dac_code);
endmodule // host_side_model

`default_nettype wire

/* File: tb/test_adc_acquisition_control.sv */
`timescale 1ns/1ps
`default_nettype none

module test_adc_acquisition_control;
    import adc_ctrl_pkg::*;
    logic clk, reset, cs_n, wr_n, rd_n, high_byte_enable, ext_run;
    logic [7:0] data_in, data_out, host_byte;
    logic data_oe_n, conv_clk_in, compare_high, track, ext_clk_sel, shutdown_active, standby_active, int_n;
    logic [RES_W-1:0] dac_code, analog;
    ctrl_s active_config;
    int failures, n_tests, cnt;

    adc_acquisition_control dut_u (.clk(clk), .reset(reset), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
        .high_byte_enable(high_byte_enable), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
        .conv_clk_in(conv_clk_in), .compare_high(compare_high), .dac_code(dac_code), .track(track),
        .active_config(active_config), .ext_clk_sel(ext_clk_sel), .shutdown_active(shutdown_active),
        .standby_active(standby_active), .int_n(int_n));
    host_side_model far_u (.clk(clk), .reset(reset), .ext_run(ext_run), .analog(analog),
        .dac_code(dac_code), .conv_clk_in(conv_clk_in), .compare_high(compare_high));

    // Bus wire: device drives it while its enable is low
    assign data_in = data_oe_n ? host_byte : data_out;

    // 10 MHz clock
    initial clk = 1'b0;
    always #50 clk = ~clk;

    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Strobe low one cycle, high the next; released bus shows the inverse byte
    task automatic write(input logic [7:0] b, input logic sel_n);
        cs_n = sel_n; wr_n = 1'b0; host_byte = b;
        @(negedge clk) wr_n = 1'b1;
        @(negedge clk) cs_n = 1'b1;
        host_byte = ~b;
    endtask

    // Bounded wait for completion; returns cycles waited
    task automatic wait_int(output int n);
        n = 0;
        while (int_n !== 1'b0 && n < 300) begin
            cycles(1);
            n++;
        end
        check(int_n, 1'b0);
    endtask

    // Both bytes of the result, pad worked out from polarity
    task automatic read_pair(input logic [11:0] res, input logic uni);
        cs_n = 1'b0; rd_n = 1'b0; high_byte_enable = 1'b0;
        cycles(2);
        check(data_oe_n, 1'b0);
        check(data_out, res[7:0]);
        check(int_n, 1'b1);
        high_byte_enable = 1'b1;
        cycles(2);
        check(data_out, {uni ? 4'h0 : {4{res[11]}}, res[11:8]});
        rd_n = 1'b1; cs_n = 1'b1; high_byte_enable = 1'b0;
        cycles(2);
        check(data_oe_n, 1'b1);
    endtask

    // On-chip clock, self-timed acquisition, unipolar single-ended
    task automatic t_int_acq;
        analog = 12'h5A3;
        write(8'h98, 1'b0);
        cycles(1);
        check(track, 1'b1);
        check(ext_clk_sel, 1'b0);
        check(active_config, 8'h98);
        cnt = 1;
        while (track === 1'b1 && cnt < 20) begin
            cycles(1);
            cnt++;
        end
        check(cnt >= 6 && cnt <= 11, 1'b1);
        cycles(36);
        check(int_n, 1'b1);
        wait_int(cnt);
        check(cnt <= 10, 1'b1);
        cycles(10);
        check(int_n, 1'b0);
        read_pair(12'h5A3, 1'b1);
    endtask

    // Pin clock, open-ended acquisition closed by a second write, bipolar pair
    task automatic t_ext_acq;
        ext_run = 1'b1;
        analog = 12'h9AB;
        write(8'hE5, 1'b0);
        cycles(30);
        check(track, 1'b1);
        check(int_n, 1'b1);
        check(active_config, 8'hE5);
        write(8'hC5, 1'b0);
        cycles(1);
        check(track, 1'b0);
        check(ext_clk_sel, 1'b1);
        cycles(42);
        check(int_n, 1'b1);
        wait_int(cnt);
        check(cnt <= 16, 1'b1);
        read_pair(12'h9AB, 1'b0);
    endtask

    // Second write closes acquisition and switches to the on-chip clock for the conversion
    task automatic t_pm_change;
        analog = 12'h3C7;
        write(8'hFA, 1'b0);
        cycles(6);
        write(8'h9A, 1'b0);
        ext_run = 1'b0;
        cycles(1);
        check(ext_clk_sel, 1'b0);
        check(active_config[2:0], 3'h2);
        wait_int(cnt);
        read_pair(12'h3C7, 1'b0);
    endtask

    // New write clears a pending flag; a write mid-conversion restarts
    task automatic t_abort;
        analog = 12'h0F1;
        write(8'h98, 1'b0);
        wait_int(cnt);
        write(8'h98, 1'b0);
        cycles(1);
        check(int_n, 1'b1);
        cycles(24);
        check(track, 1'b0);
        write(8'h99, 1'b0);
        cycles(1);
        check(track, 1'b1);
        cycles(38);
        check(int_n, 1'b1);
        wait_int(cnt);
        check(active_config[2:0], 3'h1);
        read_pair(12'h0F1, 1'b1);
    endtask

    // Power-down codes keep the clock source; deselected strobes do nothing
    task automatic t_power;
        write(8'h00, 1'b0);
        cycles(2);
        check(shutdown_active, 1'b1);
        check(ext_clk_sel, 1'b0);
        check(track, 1'b0);
        write(8'hC0, 1'b0);
        cycles(1);
        write(8'h40, 1'b0);
        cycles(2);
        check(standby_active, 1'b1);
        check(ext_clk_sel, 1'b1);
        write(8'h98, 1'b1);
        cycles(2);
        check(active_config, 8'h40);
        check(track, 1'b0);
    endtask

    task automatic results;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected few hundred cycles
    initial begin
        #2000000;
        failures++;
        results();
    end

    // Main sequence
    initial begin
        failures = 0; n_tests = 0;
        reset = 1'b1; cs_n = 1'b1; wr_n = 1'b1; rd_n = 1'b1;
        high_byte_enable = 1'b0; host_byte = 8'h00; ext_run = 1'b0; analog = 12'h000;
        repeat (6) @(negedge clk);
        reset = 1'b0;
        check(int_n, 1'b1);
        check(active_config, 8'hC0);
        check(ext_clk_sel, 1'b1);
        t_int_acq();
        t_ext_acq();
        t_pm_change();
        t_abort();
        t_power();
        results();
    end
endmodule // test_adc_acquisition_control

`default_nettype wire
